// *** shared/fpcfl_defs.svh ***
// Constants for the flyback PWM control and fault logic
`ifndef FPCFL_DEFS_SVH
`define FPCFL_DEFS_SVH
// ==========================================================
// Clock and timing
`define FPCFL_CLK_KHZ      25000
`define FPCFL_CLK_NS       40
`define FPCFL_BLANK_NS     250
`define FPCFL_BLANK_CYC    ((`FPCFL_BLANK_NS + `FPCFL_CLK_NS - 1) / `FPCFL_CLK_NS)
`define FPCFL_BO_MS        45
`define FPCFL_BO_CYC       ((`FPCFL_BO_MS * 1000000 + `FPCFL_CLK_NS - 1) / `FPCFL_CLK_NS)
`define FPCFL_SS_US        4300
`define FPCFL_SS_CYC       (`FPCFL_SS_US * 1000 / `FPCFL_CLK_NS)
// ==========================================================
// Switching frequencies in kHz and maximum duty in percent
`define FPCFL_F_NOM_LO     65
`define FPCFL_F_NOM_HI     100
`define FPCFL_F_BOOST_LO   130
`define FPCFL_F_BOOST_HI   200
`define FPCFL_F_BURST      25
`define FPCFL_MAXDUTY_PCT  80
// ==========================================================
// Fault qualification counts in switching cycles
`define FPCFL_SC_CYC       4'h8
`define FPCFL_OVP_CYC      2'h3
`define FPCFL_TSD_CYC      6'h20
`define FPCFL_OVLO_CYC     2'h3
// ==========================================================
// Feedback and current-sense levels, 20 mV per code
`define FPCFL_FB_OFFSET    8'h28
`define FPCFL_FB_STOP      8'h37
`define FPCFL_FB_BURST     8'h3C
`define FPCFL_FB_FOLD      8'h5A
`define FPCFL_FB_BOOST     8'hAF
`define FPCFL_CS_LIMIT     8'h2D
`define FPCFL_CS_MIN       8'h0A
`define FPCFL_SS_RESET     8'h00
`endif

// *** shared/fpcfl_pkg.sv ***
// Types for the flyback PWM control and fault logic
package fpcfl_pkg;
    // Comparator results from the analog front end
    typedef struct packed {
        logic vddOn;
        logic vddOff;
        logic vddOvlo;
        logic csThr;
        logic csLim;
        logic fltDis;
        logic fltBo;
        logic fltOvp;
        logic fltTsd;
    } fpcfl_cmp_t;

    typedef enum logic [1:0] {
        ST_OFF   = 2'b00,
        ST_RUN   = 2'b01,
        ST_FAULT = 2'b10
    } fpcfl_state_t;

    typedef struct packed {
        logic running;
        logic disabled;
        logic brownout;
        logic faulted;
    } fpcfl_stat_t;

    // Whole module state
    typedef struct packed {
        fpcfl_cmp_t   s1;
        fpcfl_cmp_t   s2;
        fpcfl_state_t st;
        logic [9:0]   cycCnt;
        logic [9:0]   period;
        logic [9:0]   onMax;
        logic [3:0]   blank;
        logic         gate;
        logic         scSeen;
        logic [3:0]   scCnt;
        logic [1:0]   ovpCnt;
        logic [5:0]   tsdCnt;
        logic [1:0]   ovloCnt;
        logic [23:0]  boCnt;
        logic [15:0]  ssDiv;
        logic [7:0]   ssLevel;
        logic [7:0]   csThr;
        fpcfl_stat_t  stat;
    } fpcfl_reg_t;
endpackage : fpcfl_pkg

// *** src/fpcfl_core.sv ***
// Gate-drive sequencing, control law and fault qualification of a flyback controller
// Contract
// R01 - Switch only after supply passes turn-on; stop below turn-off or above lockout.
// R02 - Ignore current-sense end of pulse during blanking after each turn-on.
// R03 - Current above limit during blanking marks the cycle as short-circuit.
// R04 - Eight consecutive short-circuit cycles engage protection and stop switching.
// R05 - Fault pin below disable level holds switching off on every variant.
// R06 - Leaving disable is immediate once the fault pin rises again.
// R07 - Brown-out stops switching only after line stays low past qualification time.
// R08 - Brown-out clears and switching resumes at once when the pin recovers.
// R09 - Overvoltage fault after pin stays high for three consecutive cycles.
// R10 - Overtemperature response after pin stays low for 32 consecutive cycles.
// R11 - Open pin on brown-out variant reads as disabled, so never starts.
// R12 - Effective feedback is the lower of feedback and soft-start ramp.
// R13 - Soft-start ramp runs from start to full in a fixed time.
// R14 - Boost region: maximum frequency, current threshold held at limit.
// R15 - Normal region: nominal frequency, threshold follows feedback.
// R16 - Foldback region: frequency and threshold both drop with feedback.
// R17 - Between stop and burst levels: lowest threshold and lowest frequency.
// R18 - Below stop level switching halts and restarts when feedback recovers.
// R19 - Latched variant holds off until power-on reset; auto variant retries.
// R20 - Undervoltage stops at once; supply overvoltage response after three cycles.
// R21 - Each consecutive-cycle counter clears in any cycle lacking its condition.
// R22 - Any disable, lockout or fault forces the gate low over everything else.
`timescale 1ns/100ps
`include "fpcfl_defs.svh"
module fpcfl_core #(
    parameter bit          BROWNOUT_VARIANT = 1'b1,
    parameter bit          LATCHED_VARIANT  = 1'b0,
    parameter bit          HIGH_FREQ        = 1'b0,
    parameter int unsigned BO_CYCLES        = `FPCFL_BO_CYC,
    parameter int unsigned SS_CYCLES        = `FPCFL_SS_CYC,
    parameter logic [7:0]  FB_FOLD          = `FPCFL_FB_FOLD,
    parameter logic [7:0]  FB_BOOST         = `FPCFL_FB_BOOST
) (
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire logic               ce,
    input  wire fpcfl_pkg::fpcfl_cmp_t cmpIn,
    input  wire logic [7:0]         fbCode,
    output logic                    gateOutput,
    output logic [7:0]              csThreshCode,
    output fpcfl_pkg::fpcfl_stat_t  status
);
    import fpcfl_pkg::*;

    // ==========================================================
    // Derived constants
    localparam int PER_NOM   = `FPCFL_CLK_KHZ / (HIGH_FREQ ? `FPCFL_F_NOM_HI : `FPCFL_F_NOM_LO);
    localparam int PER_BOOST = `FPCFL_CLK_KHZ /
                               (HIGH_FREQ ? `FPCFL_F_BOOST_HI : `FPCFL_F_BOOST_LO);
    localparam int PER_BURST = `FPCFL_CLK_KHZ / `FPCFL_F_BURST;
    localparam int FOLD_STEP = (PER_BURST - PER_NOM) / (int'(FB_FOLD) - int'(`FPCFL_FB_BURST));
    localparam int SS_STEP   = (SS_CYCLES / 256 > 0) ? SS_CYCLES / 256 : 1;
    localparam logic [3:0] BLANK_CYC = 4'(`FPCFL_BLANK_CYC);

    fpcfl_reg_t q;
    fpcfl_reg_t d;
    fpcfl_cmp_t c;
    logic [7:0] fbEff;
    logic       cycEnd;
    logic       boTrip;
    logic       inhibit;
    logic       faultTrip;
    int         perNext;
    int         csNext;

    // Synchronised comparator view; first stage is read only by the second
    assign c = q.s2;

    // Soft-start ramp clamps the feedback seen by the control law
    assign fbEff = (fbCode < q.ssLevel) ? fbCode : q.ssLevel; // [R12]

    assign cycEnd = (q.cycCnt >= q.period - 10'h001);

    // Brown-out only counts as a fault once qualified
    assign boTrip = BROWNOUT_VARIANT && (q.boCnt >= 24'(BO_CYCLES)); // [R07]

    // Open brown-out pin sits below disable, so the part never starts
    assign inhibit = c.fltDis | boTrip | c.vddOvlo | c.vddOff | (q.st != ST_RUN); // [R05] [R11]

    // ==========================================================
    // Next state
    always_comb begin
        d       = q;
        perNext = PER_NOM;
        csNext  = int'(`FPCFL_CS_MIN);
        faultTrip = 1'b0;
        d.s1    = cmpIn;
        d.s2    = q.s1;

        // Brown-out timer restarts the moment the pin recovers
        if (BROWNOUT_VARIANT && c.fltBo) begin
            if (q.boCnt < 24'(BO_CYCLES)) begin
                d.boCnt = q.boCnt + 24'h000001;
            end
        end else begin
            d.boCnt = 24'h000000; // [R08]
        end

        // Control law: period and current threshold from effective feedback
        if (fbEff >= FB_BOOST) begin
            perNext = PER_BOOST; // [R14]
            csNext  = int'(`FPCFL_CS_LIMIT);
        end else if (fbEff >= FB_FOLD) begin
            perNext = PER_NOM; // [R15]
            csNext  = (int'(fbEff) - int'(`FPCFL_FB_OFFSET)) / 2;
        end else if (fbEff >= `FPCFL_FB_BURST) begin
            perNext = PER_NOM + (int'(FB_FOLD) - int'(fbEff)) * FOLD_STEP; // [R16]
            csNext  = (int'(fbEff) - int'(`FPCFL_FB_OFFSET)) / 2;
        end else begin
            perNext = PER_BURST; // [R17]
            csNext  = int'(`FPCFL_CS_MIN);
        end
        if (csNext > int'(`FPCFL_CS_LIMIT)) begin
            csNext = int'(`FPCFL_CS_LIMIT);
        end
        if (csNext < int'(`FPCFL_CS_MIN)) begin
            csNext = int'(`FPCFL_CS_MIN);
        end

        case (q.st)
            ST_OFF: begin
                // Startup only from a clean supply
                if (c.vddOn && !c.vddOff && !c.vddOvlo) begin // [R01]
                    d.st      = ST_RUN;
                    d.cycCnt  = 10'h000;
                    d.period  = 10'(PER_BURST);
                    d.scCnt   = 4'h0;
                    d.ovpCnt  = 2'h0;
                    d.tsdCnt  = 6'h00;
                    d.ovloCnt = 2'h0;
                    d.scSeen  = 1'b0;
                    d.ssDiv   = 16'h0000;
                    d.ssLevel = `FPCFL_SS_RESET;
                end
            end
            ST_RUN: begin
                // Stepped ramp reaches full scale in the soft-start time
                if (q.ssLevel != 8'hFF) begin // [R13]
                    if (int'(q.ssDiv) >= SS_STEP - 1) begin
                        d.ssDiv   = 16'h0000;
                        d.ssLevel = q.ssLevel + 8'h01;
                    end else begin
                        d.ssDiv = q.ssDiv + 16'h0001;
                    end
                end
                d.cycCnt = cycEnd ? 10'h000 : q.cycCnt + 10'h001;
                if (cycEnd) begin
                    // Per-cycle qualification; an absent condition clears its count
                    d.scCnt   = q.scSeen ? q.scCnt + 4'h1 : 4'h0; // [R04] [R21]
                    d.ovpCnt  = (!BROWNOUT_VARIANT && c.fltOvp) ?
                                q.ovpCnt + 2'h1 : 2'h0; // [R09] [R21]
                    d.tsdCnt  = (!BROWNOUT_VARIANT && c.fltTsd) ?
                                q.tsdCnt + 6'h01 : 6'h00; // [R10] [R21]
                    d.ovloCnt = c.vddOvlo ? q.ovloCnt + 2'h1 : 2'h0; // [R20] [R21]
                    d.scSeen  = 1'b0;
                    faultTrip = (d.scCnt == `FPCFL_SC_CYC) || (d.ovpCnt == `FPCFL_OVP_CYC) ||
                                (d.tsdCnt == `FPCFL_TSD_CYC) || (d.ovloCnt == `FPCFL_OVLO_CYC);
                    d.period  = 10'(perNext);
                    d.onMax   = 10'(perNext * `FPCFL_MAXDUTY_PCT / 100);
                    d.csThr   = 8'(csNext);
                    // New pulse unless inhibited or halted below the stop level
                    if (!inhibit && fbEff >= `FPCFL_FB_STOP) begin // [R18]
                        d.gate  = 1'b1;
                        d.blank = BLANK_CYC;
                    end
                end else if (q.gate) begin
                    // Blanking hides turn-on noise but still watches for shorts
                    if (q.blank != 4'h0) begin
                        d.blank = q.blank - 4'h1; // [R02]
                        if (c.csLim) begin
                            d.scSeen = 1'b1; // [R03]
                        end
                    end else if (c.csThr) begin
                        d.gate = 1'b0;
                    end
                    if (q.cycCnt >= q.onMax) begin
                        d.gate = 1'b0;
                    end
                end
                // Undervoltage stops at once; qualified faults go to the fault state
                if (c.vddOff) begin // [R20]
                    d.st = ST_OFF;
                end else if (faultTrip) begin
                    d.st = ST_FAULT;
                end
            end
            ST_FAULT: begin
                // Auto-restart waits for a supply cycle; latched waits for power-on reset
                if (!LATCHED_VARIANT && c.vddOff) begin // [R19]
                    d.st = ST_OFF;
                end
            end
            default: begin
                d.st = ST_OFF;
            end
        endcase

        // Lockout, disable and faults override the control law
        if (inhibit || d.st != ST_RUN) begin // [R01] [R06] [R22]
            d.gate = 1'b0;
        end

        d.stat.running  = (d.st == ST_RUN);
        d.stat.disabled = c.fltDis;
        // Taken from the next count so recovery shows on the same edge
        d.stat.brownout = BROWNOUT_VARIANT && (d.boCnt >= 24'(BO_CYCLES)); // [R08]
        d.stat.faulted  = (d.st == ST_FAULT);
    end

    // ==========================================================
    // State register; clock enable freezes everything
    always_ff @(posedge clk) begin
        if (reset) begin
            q         <= '0;
            q.st      <= ST_OFF;
            q.period  <= 10'(PER_BURST);
            q.csThr   <= `FPCFL_CS_MIN;
            q.ssLevel <= `FPCFL_SS_RESET;
        end else if (ce) begin
            q <= d;
        end
    end

    // Outputs straight from flops
    assign gateOutput   = q.gate;
    assign csThreshCode = q.csThr;
    assign status       = q.stat;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_uvlo_stop;
        ce && c.vddOff |=> !gateOutput;
    endproperty
    a_uvlo_stop: assert property (p_uvlo_stop) else $error("gate high after undervoltage"); // [R20]

    property p_disable;
        ce && c.fltDis |=> !gateOutput && !status.running || !gateOutput;
    endproperty
    a_disable: assert property (p_disable) else $error("gate high while disabled"); // [R05]

    property p_brownout;
        ce && boTrip && c.fltBo |=> !gateOutput ##0 status.brownout;
    endproperty
    a_brownout: assert property (p_brownout) else $error("brown-out not stopping gate"); // [R07]

    property p_bo_clear;
        ce && BROWNOUT_VARIANT && !c.fltBo |=> q.boCnt == 24'h000000 && !status.brownout;
    endproperty
    a_bo_clear: assert property (p_bo_clear) else $error("brown-out did not clear"); // [R08]

    property p_short_trip;
        ce && q.st == ST_RUN && !c.vddOff && cycEnd && q.scSeen && q.scCnt == 4'h7
            |=> q.st == ST_FAULT && !gateOutput;
    endproperty
    a_short_trip: assert property (p_short_trip) else $error("short-circuit not engaged"); // [R04]

    property p_ovp_trip;
        ce && !BROWNOUT_VARIANT && q.st == ST_RUN && !c.vddOff && cycEnd && c.fltOvp &&
            q.ovpCnt == 2'h2 |=> status.faulted;
    endproperty
    a_ovp_trip: assert property (p_ovp_trip) else $error("overvoltage not raised"); // [R09]

    property p_tsd_trip;
        ce && !BROWNOUT_VARIANT && q.st == ST_RUN && !c.vddOff && cycEnd && c.fltTsd &&
            q.tsdCnt == 6'h1F |=> status.faulted;
    endproperty
    a_tsd_trip: assert property (p_tsd_trip) else $error("overtemperature not raised"); // [R10]

    property p_sc_clear;
        ce && q.st == ST_RUN && cycEnd && !q.scSeen |=> q.scCnt == 4'h0;
    endproperty
    a_sc_clear: assert property (p_sc_clear) else $error("short count not cleared"); // [R21]

    property p_blank_hold;
        ce && $rose(q.gate) && !inhibit ##1 ce && !inhibit |-> q.gate;
    endproperty
    a_blank_hold: assert property (p_blank_hold) else $error("pulse ended in blanking"); // [R02]

    property p_stop_halt;
        ce && q.st == ST_RUN && cycEnd && fbEff < `FPCFL_FB_STOP |=> !gateOutput;
    endproperty
    a_stop_halt: assert property (p_stop_halt) else $error("switched below stop level"); // [R18]

    property p_latched;
        LATCHED_VARIANT && q.st == ST_FAULT |=> q.st == ST_FAULT;
    endproperty
    a_latched: assert property (p_latched) else $error("latched fault released"); // [R19]
endmodule : fpcfl_core

// *** verification/fpcfl_core_tb.sv ***
// Self-checking testbench for the flyback control and fault logic
`timescale 1ns/100ps
module fpcfl_core_tb;
    import fpcfl_pkg::*;

    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        ce = 1'b1;
    fpcfl_cmp_t  tbCmp = '0;
    fpcfl_cmp_t  cmpIn;
    logic [7:0]  fbCode = 8'h64;
    logic        gateOutput;
    logic [7:0]  csThreshCode;
    fpcfl_stat_t status;
    logic        psThr;
    logic        psLim;
    logic        shortMode = 1'b0;
    int          nMismatch = 0;
    int          checksDone = 0;

    always #20 clk = ~clk;

    // Supply and pin comparators from the bench, sense comparators from the stage
    always_comb begin
        cmpIn = tbCmp;
        cmpIn.csThr = psThr;
        cmpIn.csLim = psLim;
    end

    fpcfl_core #(.BROWNOUT_VARIANT(1'b1), .LATCHED_VARIANT(1'b0), .HIGH_FREQ(1'b0),
                 .BO_CYCLES(200), .SS_CYCLES(2560)) u_dut (
        .clk(clk), .reset(reset), .ce(ce), .cmpIn(cmpIn), .fbCode(fbCode),
        .gateOutput(gateOutput), .csThreshCode(csThreshCode), .status(status));

    fpcfl_power_stage u_stage (.clk(clk), .gate(gateOutput), .csThresh(csThreshCode),
        .shortMode(shortMode), .csThr(psThr), .csLim(psLim));

    // ==========================================================
    // Shared tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            nMismatch++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    // Edges until the next gate rise; limit means it never came
    task automatic gateRise(input int limit, output int n);
        n = 0;
        while (gateOutput === 1'b1 && n < limit) begin
            @(posedge clk);
            #1 n++;
        end
        while (gateOutput !== 1'b1 && n < limit) begin
            @(posedge clk);
            #1 n++;
        end
    endtask : gateRise

    // Supply dips below turn-off, then comes back above turn-on
    task automatic powerCycle();
        @(posedge clk);
        tbCmp.vddOn <= 1'b0;
        tbCmp.vddOff <= 1'b1;
        repeat (5) @(posedge clk);
        tbCmp.vddOff <= 1'b0;
        tbCmp.vddOn <= 1'b1;
    endtask : powerCycle

    // Pin event one edge into a pulse; gate must drop on the third edge
    task automatic pinHit(input int which);
        @(posedge clk);
        if (which == 0) tbCmp.fltDis <= 1'b1;
        if (which == 1) tbCmp.vddOff <= 1'b1;
        if (which == 2) tbCmp.vddOvlo <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
    endtask : pinHit

    // ==========================================================
    // Scenarios
    task automatic testSoftStart();
        int n;
        @(posedge clk);
        fbCode <= 8'hC0;
        tbCmp.vddOn <= 1'b1;
        repeat (1000) @(posedge clk);
        gateRise(1100, n);
        gateRise(1100, n);
        check("ramp-limited period", n, 384);
        repeat (1400) @(posedge clk);
        gateRise(1100, n);
        gateRise(1100, n);
        check("full-ramp period", n, 192);
        $display("Soft-start test done");
    endtask : testSoftStart

    task automatic testControlLaw();
        logic [7:0] fbTab [5] = '{8'hC0, 8'h64, 8'h5A, 8'h4B, 8'h37};
        int         perTab [5] = '{192, 384, 384, 684, 1000};
        logic [7:0] csTab [5] = '{8'h2D, 8'h1E, 8'h19, 8'h11, 8'h0A};
        int         n;
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            fbCode <= fbTab[i];
            gateRise(1100, n);
            gateRise(1100, n);
            check("period", n, perTab[i]);
            check("sense code", csThreshCode, csTab[i]);
        end
        @(posedge clk);
        fbCode <= 8'h30;
        gateRise(2500, n);
        check("halt below stop", n, 2500);
        @(posedge clk);
        fbCode <= 8'h64;
        gateRise(1500, n);
        check("restart above stop", n < 1500, 1'b1);
        $display("Control-law test done");
    endtask : testControlLaw

    task automatic testDisable();
        int n;
        gateRise(1100, n);
        pinHit(0);
        check("gate on disable", gateOutput, 1'b0);
        check("disabled flag", status.disabled, 1'b1);
        powerCycle();
        gateRise(1500, n);
        check("open pin start", n, 1500);
        @(posedge clk);
        tbCmp.fltDis <= 1'b0;
        repeat (3) @(posedge clk);
        #1 check("disable left", status.disabled, 1'b0);
        gateRise(2500, n);
        check("switching back", n < 2500, 1'b1);
        $display("Disable test done");
    endtask : testDisable

    task automatic testBrownout();
        int n;
        @(posedge clk);
        tbCmp.fltBo <= 1'b1;
        repeat (195) @(posedge clk);
        #1 check("brownout early", status.brownout, 1'b0);
        repeat (15) @(posedge clk);
        #1 check("brownout set", status.brownout, 1'b1);
        gateRise(800, n);
        check("gate in brownout", n, 800);
        @(posedge clk);
        tbCmp.fltBo <= 1'b0;
        repeat (3) @(posedge clk);
        #1 check("brownout cleared", status.brownout, 1'b0);
        gateRise(1500, n);
        check("resume at once", n < 1500, 1'b1);
        $display("Brownout test done");
    endtask : testBrownout

    task automatic testShort();
        int n;
        int rises;
        gateRise(1100, n);
        @(posedge clk);
        shortMode <= 1'b1;
        rises = 0;
        n = 0;
        // Seven short pulses, one clean one, then shorts until protection
        while (n < 1100) begin
            gateRise(1100, n);
            if (n < 1100) rises++;
            @(posedge clk);
            // One assignment per edge: clean pulse after seven, off once tripped
            if (n < 1100) begin
                shortMode <= (rises != 7);
            end else begin
                shortMode <= 1'b0;
            end
        end
        check("pulses before trip", rises, 16);
        check("short fault", status.faulted, 1'b1);
        powerCycle();
        gateRise(2500, n);
        check("auto restart", n < 2500, 1'b1);
        $display("Short-circuit test done");
    endtask : testShort

    task automatic testSupply();
        int n;
        gateRise(1100, n);
        pinHit(1);
        check("gate on undervoltage", gateOutput, 1'b0);
        powerCycle();
        gateRise(2500, n);
        pinHit(2);
        check("gate on lockout", gateOutput, 1'b0);
        repeat (700) @(posedge clk);
        #1 check("lockout not yet", status.faulted, 1'b0);
        repeat (500) @(posedge clk);
        #1 check("lockout fault", status.faulted, 1'b1);
        // Clock enable low must freeze the fault even through a supply dip
        @(posedge clk);
        ce <= 1'b0;
        tbCmp.vddOff <= 1'b1;
        repeat (20) @(posedge clk);
        #1 check("frozen fault", status.faulted, 1'b1);
        @(posedge clk);
        tbCmp.vddOff <= 1'b0;
        repeat (4) @(posedge clk);
        ce <= 1'b1;
        repeat (4) @(posedge clk);
        #1 check("fault after freeze", status.faulted, 1'b1);
        $display("Supply test done");
    endtask : testSupply

    // ==========================================================
    // Verdict, the single end of the run
    task automatic completeRun();
        $display("Checks %0d, mismatches %0d", checksDone, nMismatch);
        if (nMismatch == 0 && checksDone > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : completeRun

    // Watchdog, well beyond the roughly 25000 clocks the scenarios need
    initial begin
        repeat (80000) @(posedge clk);
        nMismatch++;
        completeRun();
    end

    initial begin
        int n;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1 check("gate after reset", gateOutput, 1'b0);
        check("sense after reset", csThreshCode, 8'h0A);
        check("status after reset", status, 4'h0);
        gateRise(800, n);
        check("no start below turn-on", n, 800);
        $display("Idle test done");
        testSoftStart();
        testControlLaw();
        testDisable();
        testBrownout();
        testShort();
        testSupply();
        completeRun();
    end
endmodule : fpcfl_core_tb

// *** verification/fpcfl_power_stage.sv ***
// Behavioural power stage: primary current ramp and current-sense comparators
`timescale 1ns/100ps
module fpcfl_power_stage (
    input  wire logic       clk,
    input  wire logic       gate,
    input  wire logic [7:0] csThresh,
    input  wire logic       shortMode,
    output logic            csThr,
    output logic            csLim
);
    logic [7:0] current_r = 8'h00;

    // ==========================================================
    // Current ramp
    // Climbs one code a clock while the switch conducts, collapses when it opens
    always_ff @(posedge clk) begin
        if (gate !== 1'b1) begin
            current_r <= 8'h00;
        end else if (shortMode && current_r == 8'h00) begin
            current_r <= 8'h40;                 // Shorted output jumps at turn-on
        end else if (current_r != 8'hFF) begin
            current_r <= current_r + 8'h01;
        end
    end

    // Comparators see the ramp right away, no filtering
    assign csThr = (current_r > csThresh);
    assign csLim = (current_r > 8'h2D);
endmodule : fpcfl_power_stage
